// *** hw/dlm_pkg.sv ***
/*
 * Constants for the memory lane map and capacity block: arrangement codes,
 * lane and strobe masks per arrangement, capacity figures and the Mbit size.
 * Assumes a 36-bit internal word and up to four x16 memory chips.
 */
package dlm_pkg;

    localparam int DLM_WORD_W = 36;
    localparam int DLM_DQ_W = 64;
    localparam int DLM_DQS_W = 8;
    localparam int DLM_CHECK_W = 8;

    // Arrangement codes on the three static select pins
    localparam logic [2:0] DLM_SEL_X32_OFF = 3'h0;
    localparam logic [2:0] DLM_SEL_X16_OFF = 3'h1;
    localparam logic [2:0] DLM_SEL_X32_ON = 3'h2;
    localparam logic [2:0] DLM_SEL_X16_ON = 3'h3;
    localparam logic [2:0] DLM_SEL_X36_ON = 3'h6;
    localparam logic [2:0] DLM_SEL_X36_OFF = 3'h4;
    localparam logic [2:0] DLM_SEL_X64_ON = 3'h5;
    localparam logic [2:0] DLM_SEL_X64_OFF = 3'h7;
    localparam logic [2:0] DLM_SEL_RESET = 3'h7;

    // Connected data lanes per arrangement
    localparam logic [6:0] DLM_LANES_16 = 7'd16;
    localparam logic [6:0] DLM_LANES_32 = 7'd32;
    localparam logic [6:0] DLM_LANES_36 = 7'd36;
    localparam logic [6:0] DLM_LANES_64 = 7'd64;
    localparam logic [63:0] DLM_MASK_16 = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] DLM_MASK_32 = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] DLM_MASK_36 = 64'h0000_000F_FFFF_FFFF;
    localparam logic [63:0] DLM_MASK_64 = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [7:0] DLM_SMASK_16 = 8'h03;
    localparam logic [7:0] DLM_SMASK_32 = 8'h0F;
    localparam logic [7:0] DLM_SMASK_36 = 8'h3F;
    localparam logic [7:0] DLM_SMASK_64 = 8'hFF;

    // Usable capacity in Mbit with 16Mb x 16 chips
    localparam logic [10:0] DLM_CAP_X64_OFF = 11'd1008;
    localparam logic [10:0] DLM_CAP_X64_ON = 11'd576;
    localparam logic [10:0] DLM_CAP_X36_OFF = 11'd567;
    localparam logic [10:0] DLM_CAP_X36_ON = 11'd504;
    localparam logic [10:0] DLM_CAP_X32_OFF = 11'd504;
    localparam logic [10:0] DLM_CAP_X32_ON = 11'd288;
    localparam logic [10:0] DLM_CAP_X16_OFF = 11'd216;
    localparam logic [10:0] DLM_CAP_X16_ON = 11'd144;
    localparam longint DLM_MBIT = 64'd1048576;

    // Write slot within a correction group
    typedef enum logic [2:0] {
        DLM_SLOT_D0 = 3'b001,
        DLM_SLOT_D1 = 3'b010,
        DLM_SLOT_CK = 3'b100
    } dlm_slot_t;

endpackage

// *** hw/dlm_two_buf.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes push and pop on the same clock; ready and valid come from flops.
 */
`timescale 1ns/1ps
module dlm_two_buf #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 2
) (
    input wire logic clk_in,               // Block clock
    input wire logic reset_in,             // Async reset, active high
    input wire logic [WIDTH-1:0] in_data_in, // Word to store
    input wire logic in_valid_in,          // Word offered
    output logic in_ready_out,             // Room for a word
    output logic [WIDTH-1:0] out_data_out, // Oldest word
    output logic out_valid_out,            // Oldest word present
    input wire logic out_ready_in          // Drain side takes the word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data_out = mem_q[rd_q];
    assign out_valid_out = (cnt_q != '0);

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_out <= 1'b1;
        end else begin
            wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
            rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
            cnt_q <= cnt_d;
            in_ready_out <= (cnt_d < (AW+1)'(DEPTH));
        end
    end
endmodule // dlm_two_buf

// *** hw/dlm_lane_map.sv ***
/*
 * Write and read lane mapping of the external memory data path: splits
 * 36-bit words over the connected lanes, inserts check-bit beats when
 * correction is on, tracks usable capacity and raises full.
 * Assumes the memory strobe clock arrives on a pin, slower than clk_in,
 * and that the arrangement select pins are static.
 */
// Summary of operation
// - Words do not fill lanes evenly; leftover connected lanes are driven low and leftover columns stay unwritten.
// - With correction, eight check bits are computed per 64-bit data block.
// - With correction, every third write beat carries check bits, not data.
// - The check beat leaves its remaining bit positions unused.
// - Four x16 chips give 1008Mb without correction, 576Mb with; full follows.
// - Three chips, third four bits wide, give 567Mb off, 504Mb on.
// - Four chips use 16-lane groups; strobes 2n and 2n+1 serve chip n.
// - With correction each group is two data beats then one check beat.
`timescale 1ns/1ps
module dlm_lane_map #(
    parameter int LIMIT_SHIFT = 0 // Scales the word limit down by a power of two; 0 is the full device
) (
    input wire logic clk_in,                     // 40 MHz block clock
    input wire logic reset_in,                   // Async reset, active high
    input wire logic [2:0] memory_arrangement_select_in, // Static arrangement pins
    input wire logic link_clk_in,                // Memory strobe clock pin
    input wire logic [dlm_pkg::DLM_WORD_W-1:0] wr_data_in, // Word to store
    input wire logic wr_valid_in,                // Word offered
    output logic wr_ready_out,                   // Buffer room
    input wire logic rd_en_in,                   // Capture read beats
    output logic [dlm_pkg::DLM_DQ_W-1:0] rd_beat_out, // Captured lanes, masked
    output logic rd_valid_out,                   // Pulse per captured beat
    output logic [dlm_pkg::DLM_DQ_W-1:0] dq_out, // Data lane drive
    output logic [dlm_pkg::DLM_DQ_W-1:0] dq_oe_out, // Data lane enable
    input wire logic [dlm_pkg::DLM_DQ_W-1:0] dq_in, // Data lane level
    output logic [dlm_pkg::DLM_DQS_W-1:0] dqs_out, // Strobe drive
    output logic [dlm_pkg::DLM_DQS_W-1:0] dqs_oe_out, // Strobe enable
    output logic ecc_on_out,                     // Correction selected
    output logic [10:0] capacity_mbit_out,       // Usable capacity
    output logic full_out                        // Capacity reached
);
    import dlm_pkg::*;

    // Static select pins: three flops, accepted on agreement; strobe clock: three flops, edge from the last two
    logic [2:0] sel_s1_q, sel_s2_q, sel_s3_q, sel_q;
    logic [2:0] lk_q;
    logic [DLM_DQ_W-1:0] dq_s1_q, dq_s2_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sel_s1_q <= DLM_SEL_RESET;
            sel_s2_q <= DLM_SEL_RESET;
            sel_s3_q <= DLM_SEL_RESET;
            sel_q <= DLM_SEL_RESET;
            lk_q <= 3'h0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            sel_s1_q <= memory_arrangement_select_in;
            sel_s2_q <= sel_s1_q;
            sel_s3_q <= sel_s2_q;
            if (sel_s2_q == sel_s3_q) begin
                sel_q <= sel_s3_q;
            end
            lk_q <= {lk_q[1:0], link_clk_in};
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end
    wire beat_edge = lk_q[1] && !lk_q[2];

    // Arrangement decode
    wire sel_x16 = (sel_q == DLM_SEL_X16_OFF) || (sel_q == DLM_SEL_X16_ON);
    wire sel_x32 = (sel_q == DLM_SEL_X32_OFF) || (sel_q == DLM_SEL_X32_ON);
    wire sel_x36 = (sel_q == DLM_SEL_X36_OFF) || (sel_q == DLM_SEL_X36_ON);
    wire ecc_on = (sel_q == DLM_SEL_X16_ON) || (sel_q == DLM_SEL_X32_ON) ||
                  (sel_q == DLM_SEL_X36_ON) || (sel_q == DLM_SEL_X64_ON);
    wire [6:0] lanes = sel_x16 ? DLM_LANES_16 : sel_x32 ? DLM_LANES_32 :
                       sel_x36 ? DLM_LANES_36 : DLM_LANES_64;
    wire [63:0] lane_mask = sel_x16 ? DLM_MASK_16 : sel_x32 ? DLM_MASK_32 :
                            sel_x36 ? DLM_MASK_36 : DLM_MASK_64;
    wire [7:0] strobe_mask = sel_x16 ? DLM_SMASK_16 : sel_x32 ? DLM_SMASK_32 :
                             sel_x36 ? DLM_SMASK_36 : DLM_SMASK_64;
    wire [1:0] last_beat = sel_x16 ? 2'd2 : sel_x32 ? 2'd1 : 2'd0;
    wire [10:0] cap = sel_x16 ? (ecc_on ? DLM_CAP_X16_ON : DLM_CAP_X16_OFF) :
                      sel_x32 ? (ecc_on ? DLM_CAP_X32_ON : DLM_CAP_X32_OFF) :
                      sel_x36 ? (ecc_on ? DLM_CAP_X36_ON : DLM_CAP_X36_OFF) :
                      (ecc_on ? DLM_CAP_X64_ON : DLM_CAP_X64_OFF);
    wire [63:0] cap_bits = (64'(cap) * DLM_MBIT) >> LIMIT_SHIFT;
    wire [31:0] word_limit = 32'(cap_bits / 64'(DLM_WORD_W));

    // Input buffer
    logic [DLM_WORD_W-1:0] buf_data;
    logic buf_valid;
    logic take;
    dlm_two_buf #(.WIDTH(DLM_WORD_W), .DEPTH(2)) u_buf (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_data_in(wr_data_in),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .out_data_out(buf_data),
        .out_valid_out(buf_valid),
        .out_ready_in(take)
    );

    // Check byte over one 64-bit block: six position parities, overall, even bits
    function automatic logic [7:0] check_byte(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int j = 0; j < 64; j++) begin
            for (int i = 0; i < 6; i++) begin
                if (j[i]) begin
                    c[i] = c[i] ^ d[j];
                end
            end
            c[6] = c[6] ^ d[j];
            if (!j[0]) begin
                c[7] = c[7] ^ d[j];
            end
        end
        return c;
    endfunction

    logic [DLM_WORD_W-1:0] word_q;
    logic have_q;
    logic [1:0] beat_q;
    dlm_slot_t slot_q;
    logic [63:0] hold0_q, hold1_q;
    logic [31:0] words_q;
    logic full_q;

    assign take = buf_valid && !have_q && !full_q;
    wire [6:0] shamt = 7'(beat_q * lanes);
    wire [63:0] data_beat = ({28'h0, word_q} >> shamt) & lane_mask;
    wire in_check = ecc_on && (slot_q == DLM_SLOT_CK);
    wire emit_check = beat_edge && in_check;
    wire emit_data = beat_edge && !in_check && have_q;
    wire emit = emit_check || emit_data;
    wire narrow = sel_x16 || sel_x32;
    wire [63:0] block_a = narrow ? {hold1_q[31:0], hold0_q[31:0]} : hold0_q;
    wire [7:0] chk_a = check_byte(block_a);
    wire [7:0] chk_b = narrow ? 8'h00 : check_byte(hold1_q);
    wire [63:0] check_beat = {48'h0, chk_b, chk_a} & lane_mask;
    wire word_done = emit_data && (beat_q == last_beat);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            word_q <= '0;
            have_q <= 1'b0;
            beat_q <= 2'd0;
        end else if (take) begin
            word_q <= buf_data;
            have_q <= 1'b1;
            beat_q <= 2'd0;
        end else if (emit_data) begin
            have_q <= !word_done;
            beat_q <= word_done ? 2'd0 : beat_q + 2'd1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            slot_q <= DLM_SLOT_D0;
            hold0_q <= '0;
            hold1_q <= '0;
        end else if (!ecc_on) begin
            slot_q <= DLM_SLOT_D0;
        end else if (emit) begin
            case (slot_q)
                DLM_SLOT_D0: begin
                    hold0_q <= data_beat;
                    slot_q <= DLM_SLOT_D1;
                end
                DLM_SLOT_D1: begin
                    hold1_q <= data_beat;
                    slot_q <= DLM_SLOT_CK;
                end
                DLM_SLOT_CK: begin
                    slot_q <= DLM_SLOT_D0;
                end
                default: begin
                    slot_q <= DLM_SLOT_D0;
                end
            endcase
        end
    end

    // Capacity count: one per word accepted
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            words_q <= 32'h0000_0000;
            full_q <= 1'b0;
        end else begin
            words_q <= take ? words_q + 32'h0000_0001 : words_q;
            full_q <= ((take ? words_q + 32'h0000_0001 : words_q) >= word_limit);
        end
    end

    // Pin drive and read capture
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dq_out <= '0;
            dq_oe_out <= '0;
            dqs_out <= '0;
            dqs_oe_out <= '0;
            rd_beat_out <= '0;
            rd_valid_out <= 1'b0;
            ecc_on_out <= 1'b0;
            capacity_mbit_out <= 11'h000;
            full_out <= 1'b0;
        end else begin
            if (emit) begin
                dq_out <= emit_check ? check_beat : data_beat;
                dq_oe_out <= lane_mask;
                dqs_out <= (dqs_out ^ strobe_mask) & strobe_mask;
                dqs_oe_out <= strobe_mask;
            end else if (beat_edge) begin
                dq_out <= '0;
                dq_oe_out <= '0;
                dqs_out <= '0;
                dqs_oe_out <= '0;
            end
            rd_valid_out <= beat_edge && rd_en_in;
            if (beat_edge && rd_en_in) begin
                rd_beat_out <= dq_s2_q & lane_mask;
            end
            ecc_on_out <= ecc_on;
            capacity_mbit_out <= cap;
            full_out <= full_q;
        end
    end
endmodule // dlm_lane_map

// *** verif/dlm_lane_map_checker.sv ***
/* Port checker for dlm_lane_map.
   Sees only top-level ports; bound at the foot of this file. */
`timescale 1ns/1ps
module dlm_lane_map_checker (
    input wire logic clk_in, // Clock
    input wire logic reset_in, // Reset
    input wire logic [2:0] memory_arrangement_select_in, // Select pins
    input wire logic wr_ready_out, // Buffer room
    input wire logic rd_valid_out, // Read pulse
    input wire logic [dlm_pkg::DLM_DQ_W-1:0] rd_beat_out, // Read beat
    input wire logic [dlm_pkg::DLM_DQ_W-1:0] dq_out, // Lane drive
    input wire logic [dlm_pkg::DLM_DQ_W-1:0] dq_oe_out, // Lane enable
    input wire logic [dlm_pkg::DLM_DQS_W-1:0] dqs_out, // Strobe drive
    input wire logic [dlm_pkg::DLM_DQS_W-1:0] dqs_oe_out, // Strobe enable
    input wire logic ecc_on_out, // Correction on
    input wire logic [10:0] capacity_mbit_out // Capacity
);
    import dlm_pkg::*;
    // Mbit per select code
    localparam logic [10:0] CAP_T [8] = '{11'h1f8, 11'h0d8, 11'h120, 11'h090, 11'h237, 11'h240, 11'h1f8, 11'h3f0};
    localparam logic [63:0] LM_T [4] = '{DLM_MASK_16, DLM_MASK_32, DLM_MASK_36, DLM_MASK_64};
    localparam logic [7:0] SM_T [4] = '{8'h03, 8'h0f, 8'h3f, 8'hff};
    logic [1:0] arr;
    logic [3:0] st_q;
    logic [1:0] slot_q;
    logic [7:0] dqs_q;
    logic beat;
    // Arrangement read back from the capacity it reports
    assign arr = (capacity_mbit_out inside {11'h0d8, 11'h090}) ? 2'd0 :
        (capacity_mbit_out == 11'h120 || (capacity_mbit_out == 11'h1f8 && !ecc_on_out)) ? 2'd1 :
        (capacity_mbit_out inside {11'h237, 11'h1f8}) ? 2'd2 : 2'd3;
    assign beat = dqs_out != dqs_q && dq_oe_out != '0;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= '0;
            slot_q <= '0;
            dqs_q <= '0;
        end else begin
            st_q <= $changed(memory_arrangement_select_in) ? 4'h0 : (st_q == 4'hf ? st_q : st_q + 4'h1);
            slot_q <= (beat && ecc_on_out) ? (slot_q == 2'd2 ? 2'd0 : slot_q + 2'd1) : slot_q;
            dqs_q <= dqs_out;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    lane_oe_mask_a: assert property ((dq_oe_out & ~LM_T[arr]) == '0) else $error("Lane enabled off map");
    lane_out_mask_a: assert property ((dq_out & ~LM_T[arr]) == '0) else $error("Lane driven off map");
    strobe_mask_a: assert property (((dqs_oe_out | dqs_out) & ~SM_T[arr]) == '0) else $error("Bad strobe");
    read_mask_a: assert property (rd_valid_out |-> (rd_beat_out & ~LM_T[arr]) == '0) else $error("Read unmasked");
    ecc_cap_a: assert property (ecc_on_out |-> capacity_mbit_out inside {11'h240, 11'h1f8, 11'h120, 11'h090})
        else $error("Capacity wrong with correction");
    plain_cap_a: assert property (!ecc_on_out && capacity_mbit_out != '0 |->
        capacity_mbit_out inside {11'h3f0, 11'h237, 11'h1f8, 11'h0d8}) else $error("Capacity wrong");
    cap_select_a: assert property (st_q == 4'hf |-> capacity_mbit_out == CAP_T[memory_arrangement_select_in])
        else $error("Capacity does not follow select");
    check_slot_a: assert property (beat && ecc_on_out && slot_q == 2'd2 |-> dq_out[63:16] == '0)
        else $error("Third beat is not a check beat");
    beat_gap_a: assert property ($changed(dqs_out) |=> !$changed(dqs_out) [*6]) else $error("Beats too close");
    ecc_beat_c: cover property (beat && ecc_on_out && slot_q == 2'd2);
    read_c: cover property (rd_valid_out);
    stall_c: cover property ($fell(wr_ready_out));
endmodule // dlm_lane_map_checker

bind dlm_lane_map dlm_lane_map_checker u_chk (.clk_in, .reset_in, .memory_arrangement_select_in, .wr_ready_out,
    .rd_valid_out, .rd_beat_out, .dq_out, .dq_oe_out, .dqs_out, .dqs_oe_out, .ecc_on_out, .capacity_mbit_out);

// *** verif/dlm_mem_model.sv ***
/* Behavioural model of the memory chips on the lane side.
   Makes the strobe clock and resolves lane levels; unwired lanes read high. */
`timescale 1ns/1ps
module dlm_mem_model (
    output logic link_clk_out, // Memory strobe clock
    input wire logic [63:0] dq_out_in, // Lane drive from the block
    input wire logic [63:0] dq_oe_in, // Lane enable from the block
    input wire logic [63:0] lane_mask_in, // Lanes wired to a chip
    output logic [63:0] dq_level_out, // Resolved lane level
    output logic [63:0] rd_word_out // Data the chips present
);
    initial begin
        link_clk_out = 1'b0;
        rd_word_out = 64'h0;
        #37;
        forever #100 link_clk_out = ~link_clk_out;
    end
    // New data away from the rising edge that the block samples near
    always @(negedge link_clk_out)
        rd_word_out <= {$urandom, $urandom};
    assign dq_level_out = (dq_oe_in & dq_out_in) | (~dq_oe_in & ((rd_word_out & lane_mask_in) | ~lane_mask_in));
endmodule // dlm_mem_model

// *** verif/testbench.sv ***
/* Self-checking bench for dlm_lane_map: walks every select code, streams words
   and reads beats back. Assumes dlm_mem_model stands in for the chips. */
`timescale 1ns/1ps
module testbench;
    import dlm_pkg::*;
    localparam logic [2:0] CODES [8] = '{3'h7, 3'h1, 3'h0, 3'h4, 3'h6, 3'h5, 3'h2, 3'h3};
    localparam logic [10:0] CAPS [8] = '{11'h3f0, 11'h0d8, 11'h1f8, 11'h237, 11'h1f8, 11'h240, 11'h120, 11'h090};
    localparam logic [63:0] LM_T [4] = '{DLM_MASK_16, DLM_MASK_32, DLM_MASK_36, DLM_MASK_64};
    localparam logic [7:0] SM_T [4] = '{8'h03, 8'h0f, 8'h3f, 8'hff};
    // Word limit scaled down so that full is reachable in a short run
    localparam int SHIFT = 18;
    logic clk_in, reset_in, link_clk, wr_valid_in, rd_en_in, wr_ready_out, rd_valid_out, ecc_on_out, full_out, ecc;
    logic [2:0] sel;
    logic [35:0] wr_data;
    logic [63:0] rd_beat_out, dq_out, dq_oe_out, dq_level, rd_word, lmask, d0, r;
    logic [7:0] dqs_out, dqs_oe_out, smask, dqs_p;
    logic [10:0] capacity_mbit_out;
    logic [1:0] w;
    int n_errors, comparisons, nw, seed, lim;
    logic [63:0] wq[$];
    logic [63:0] rq[$];

    dlm_lane_map #(.LIMIT_SHIFT(SHIFT)) dut (.clk_in, .reset_in, .memory_arrangement_select_in(sel),
        .link_clk_in(link_clk), .wr_data_in(wr_data), .wr_valid_in, .wr_ready_out, .rd_en_in, .rd_beat_out,
        .rd_valid_out, .dq_out,
        .dq_oe_out, .dq_in(dq_level), .dqs_out, .dqs_oe_out, .ecc_on_out, .capacity_mbit_out, .full_out);
    dlm_mem_model mem (.link_clk_out(link_clk), .dq_out_in(dq_out), .dq_oe_in(dq_oe_out), .lane_mask_in(lmask),
        .dq_level_out(dq_level), .rd_word_out(rd_word));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic compare(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] ck(input logic [63:0] d);
        ck = 8'h00;
        for (int j = 0; j < 64; j++) begin
            for (int i = 0; i < 6; i++)
                ck[i] = ck[i] ^ (j[i] & d[j]);
            ck[6] = ck[6] ^ d[j];
            ck[7] = ck[7] ^ (!j[0] & d[j]);
        end
    endfunction

    task automatic setup(input logic [2:0] code);
        @(negedge clk_in);
        reset_in <= 1'b1;
        sel <= code;
        w = {code[2], code[2] ~^ code[0]};
        ecc = code[1] ^ (code[2] & code[0]);
        lmask = LM_T[w];
        smask = SM_T[w];
        nw = 0;
        repeat (3) @(negedge clk_in);
        reset_in <= 1'b0;
        repeat (20) @(negedge clk_in);
    endtask

    // Notes one data beat; with correction a check beat follows every second one
    task automatic note(input logic [63:0] b);
        wq.push_back(b);
        if (ecc && nw[0])
            wq.push_back((w[1] ? {48'h0, ck(b), ck(d0)} : {56'h0, ck({b[31:0], d0[31:0]})}) & lmask);
        d0 = b;
        nw++;
    endtask

    // Notes the beats a word should become (when keep), then offers it until taken
    task automatic send(input logic [35:0] word, input bit keep);
        if (keep) begin
            if (w == 2'd0) begin
                note({48'h0, word[15:0]});
                note({48'h0, word[31:16]});
            end
            if (w == 2'd1)
                note({32'h0, word[31:0]});
            note(w[1] ? {28'h0, word} : {60'h0, word[35:32]});
        end
        wr_data <= word;
        wr_valid_in <= 1'b1;
        for (int i = 0; i < 400 && !wr_ready_out; i++)
            @(negedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic drain();
        wr_valid_in <= 1'b0;
        for (int i = 0; i < 600 && wq.size() != 0; i++)
            @(negedge clk_in);
        // Let an idle beat release the lanes before any read
        repeat (2) @(negedge link_clk);
        compare(64'(wq.size()), 64'h0, "beats missing");
    endtask

    task automatic read_beats();
        @(negedge link_clk);
        @(negedge clk_in);
        rd_en_in <= 1'b1;
        repeat (4) @(negedge link_clk);
        @(negedge clk_in);
        rd_en_in <= 1'b0;
        repeat (40) @(negedge clk_in);
        compare(64'(rq.size()), 64'h0, "reads missing");
    endtask

    always @(posedge link_clk)
        if (rd_en_in && !reset_in)
            rq.push_back(rd_word & lmask);

    always @(negedge clk_in) begin
        if (!reset_in && dqs_out !== dqs_p && dq_oe_out != 64'h0) begin
            compare(dq_out, wq.size() != 0 ? wq.pop_front() : 64'hx, "beat");
            compare({56'h0, dqs_oe_out}, {56'h0, smask}, "strobes");
            compare({56'h0, dqs_out}, {56'h0, dqs_p ^ smask}, "strobe level");
        end
        if (rd_valid_out)
            compare(rd_beat_out, rq.size() != 0 ? rq.pop_front() : 64'hx, "read");
        dqs_p = dqs_out;
    end

    initial begin
        reset_in = 1'b1;
        sel = 3'h7;
        wr_valid_in = 1'b0;
        rd_en_in = 1'b0;
        wr_data = 36'h0;
        n_errors = 0;
        comparisons = 0;
        seed = $urandom(32'h0db3);
        for (int c = 0; c < 8; c++) begin
            setup(CODES[c]);
            compare({53'h0, capacity_mbit_out}, {53'h0, CAPS[c]}, "capacity");
            compare({63'h0, ecc_on_out}, {63'h0, ecc}, "correction");
            lim = (c == 7) ? ((int'(CAPS[c]) << (20 - SHIFT)) / DLM_WORD_W) : 6;
            for (int i = 0; i < lim; i++) begin
                r = {$urandom, $urandom};
                send(i == 0 ? 36'hf_ffff_ffff : r[35:0], 1'b1);
            end
            drain();
            compare({63'h0, full_out}, {63'h0, c == 7}, "full");
            if (c == 7) begin
                // One word past the limit must stay parked and never reach the lanes
                send(36'h5_a5a5_a5a5, 1'b0);
                drain();
            end
            read_beats();
        end
        results();
    end

    initial begin
        #(25 * 40000);
        n_errors++;
        results();
    end
endmodule // testbench
